// >>> vpm_map_regs.sv
`timescale 1ns/1ps
module vpm_map_regs
  import vpm_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire vpm_req_t    req_i,
  input  wire vpm_cfg_t    cfg_i,
  input  wire logic [63:0] identity_i,
  input  wire logic [63:0] hyp_ctrl_i,
  input  wire logic [31:0] valid_bits_i,
  input  wire logic [51:0] redirect_base_address_i,
  input  wire logic        use_kernel_label_i,
  input  wire logic [15:0] label_id_i,
  output logic             ack_o,
  output vpm_res_t         res_o,
  output logic [63:0]      rdata_o,
  output logic [63:0]      mem_addr_o,
  output logic [15:0]      out_id_o,
  output logic             out_mapped_o
);

  logic [63:0] map1;
  logic [63:0] map2;
  logic [63:0] map3;
  logic [2:0]  idx_max;
  logic        virt_on;
  logic        hit;
  logic [2:0]  sel;
  logic        present;
  vpm_res_t    chk;
  logic        do_acc;
  logic [63:0] ofs;
  logic [15:0] lk_pid;
  logic        lk_hit;
  logic        map_en;
  logic [4:0]  vslot;

  // Identity fields; index-max forced to zero without virtualisation
  assign virt_on = identity_i[VPM_VIRT_BIT];
  assign idx_max = virt_on ? identity_i[VPM_IDXMAX_LSB +: 3] : 3'h0;

  // Encoding decode
  assign hit = (req_i.op0 == VPM_OP0) && (req_i.op1 == VPM_OP1)
            && (req_i.crn == VPM_CRN) && (req_i.crm == VPM_CRM);
  assign sel = req_i.op2;
  // Register n present only when index-max reaches n
  assign present = hit && virt_on && (sel >= VPM_OP2_REG1) && (sel <= VPM_OP2_REG3)
                && (idx_max >= sel);

  vpm_access_check u_chk
  (
    .cfg_i     (cfg_i),
    .el_i      (req_i.el),
    .present_i (present),
    .res_o     (chk)
  );

  assign do_acc = req_i.valid && hit && (chk == VPM_RES_OK);

  // Memory offset for redirected accesses
  always_comb
  begin
    unique case (sel)
      VPM_OP2_REG1: ofs = VPM_OFS_REG1;
      VPM_OP2_REG2: ofs = VPM_OFS_REG2;
      default:      ofs = VPM_OFS_REG3;
    endcase
  end

  // Storage has no reset: contents are unknown until software writes them
  always_ff @(posedge clock_i)
  begin
    if (do_acc && req_i.write)
    begin
      if (sel == VPM_OP2_REG1)
        map1 <= req_i.wdata;
      if (sel == VPM_OP2_REG2)
        map2 <= req_i.wdata;
      if (sel == VPM_OP2_REG3)
        map3 <= req_i.wdata;
    end
  end

  // Access answer, one cycle after the request
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_o      <= 1'b0;
      res_o      <= VPM_RES_OK;
      rdata_o    <= 64'h0;
      mem_addr_o <= 64'h0;
    end
    else
    begin
      ack_o      <= req_i.valid && hit;
      res_o      <= chk;
      mem_addr_o <= (chk == VPM_RES_MEM)
                  ? ({12'h000, redirect_base_address_i} << VPM_BADDR_SHIFT) + ofs
                  : 64'h0;
      if (do_acc && !req_i.write)
        rdata_o <= (sel == VPM_OP2_REG1) ? map1
                 : (sel == VPM_OP2_REG2) ? map2 : map3;
      else
        rdata_o <= 64'h0;
    end
  end

  vpm_entry_lookup u_lk
  (
    .map1_i (map1),
    .map2_i (map2),
    .map3_i (map3),
    .vid_i  (label_id_i),
    .pid_o  (lk_pid),
    .hit_o  (lk_hit)
  );

  // Mapping enable chosen by label source; needs level 2 enabled
  assign map_en = (use_kernel_label_i ? hyp_ctrl_i[VPM_KERNEL_EN_BIT]
                                      : hyp_ctrl_i[VPM_USER_EN_BIT])
               && (cfg_i.nonsecure_bit || cfg_i.secure_level2_enable)
               && virt_on;
  assign vslot = label_id_i[4:0];

  // Translated label; invalid or out-of-range entries pass through
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_id_o     <= 16'h0;
      out_mapped_o <= 1'b0;
    end
    else if (map_en && lk_hit && valid_bits_i[vslot]
             && (label_id_i[15:2] <= {11'h0, idx_max}))
    begin
      out_id_o     <= lk_pid;
      out_mapped_o <= 1'b1;
    end
    else
    begin
      out_id_o     <= label_id_i;
      out_mapped_o <= 1'b0;
    end
  end

  a_el2_trap: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (req_i.valid && present && req_i.el == VPM_EL2 && cfg_i.lower_level_trap_bit
     && (cfg_i.nonsecure_bit || cfg_i.secure_level2_enable))
    |=> (ack_o && res_o == VPM_RES_TRAP3))
    else $error("level-2 access not trapped to level 3");

  a_el1_trap2: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (req_i.valid && present && req_i.el == VPM_EL1 && !cfg_i.lower_level_trap_bit
     && (cfg_i.nonsecure_bit || cfg_i.secure_level2_enable) && cfg_i.el2_is_64bit
     && cfg_i.host_mode_bit && cfg_i.nested_virt_enable
     && !cfg_i.nested_memory_redirect_bit && !cfg_i.host_traps_all_bit)
    |=> res_o == VPM_RES_TRAP2)
    else $error("level-1 access not trapped to level 2");

  a_el0_denied: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (req_i.valid && hit && req_i.el == VPM_EL0) |=> res_o == VPM_RES_UNDEF)
    else $error("level-0 access granted");

  a_el3_granted: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (req_i.valid && present && req_i.el == VPM_EL3) |=> res_o == VPM_RES_OK)
    else $error("level-3 access refused");

  a_redirect_addr: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (req_i.valid && present && req_i.el == VPM_EL1 && sel == VPM_OP2_REG2
     && cfg_i.nested_virt_enable && cfg_i.nested_memory_redirect_bit
     && !(cfg_i.host_traps_all_bit && (cfg_i.nonsecure_bit || cfg_i.secure_level2_enable)))
    |=> mem_addr_o[11:0] == 12'h950)
    else $error("redirect address wrong");

  a_write_read: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (do_acc && req_i.write && sel == VPM_OP2_REG2) ##1
    (do_acc && !req_i.write && sel == VPM_OP2_REG2) |=> rdata_o == $past(req_i.wdata, 2))
    else $error("read after write mismatch");

  a_reg2_absent: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (req_i.valid && hit && sel == VPM_OP2_REG2 && idx_max < 3'h2)
    |=> res_o == VPM_RES_UNDEF)
    else $error("absent register 2 accessible");

  a_map_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !(cfg_i.nonsecure_bit || cfg_i.secure_level2_enable)
    |=> (!out_mapped_o && out_id_o == $past(label_id_i)))
    else $error("mapping applied with level 2 off");

  a_invalid_entry: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !valid_bits_i[vslot] |=> !out_mapped_o)
    else $error("invalid entry used");

endmodule // vpm_map_regs

// >>> vpm_pkg.sv
package vpm_pkg;

  // System-register encoding of the mapping registers
  localparam logic [1:0]  VPM_OP0       = 2'h3;
  localparam logic [2:0]  VPM_OP1       = 3'h4;
  localparam logic [3:0]  VPM_CRN       = 4'ha;
  localparam logic [3:0]  VPM_CRM       = 4'h6;
  localparam logic [2:0]  VPM_OP2_REG1  = 3'h1;
  localparam logic [2:0]  VPM_OP2_REG2  = 3'h2;
  localparam logic [2:0]  VPM_OP2_REG3  = 3'h3;

  // Redirect offsets under nested virtualisation
  localparam logic [63:0] VPM_OFS_REG1  = 64'h0000_0000_0000_0948;
  localparam logic [63:0] VPM_OFS_REG2  = 64'h0000_0000_0000_0950;
  localparam logic [63:0] VPM_OFS_REG3  = 64'h0000_0000_0000_0958;
  localparam int unsigned VPM_BADDR_SHIFT = 12;

  // Field positions
  localparam int unsigned VPM_ENTRY_W      = 16;
  localparam int unsigned VPM_KERNEL_EN_BIT = 1;
  localparam int unsigned VPM_USER_EN_BIT   = 0;
  localparam int unsigned VPM_IDXMAX_LSB    = 18;
  localparam int unsigned VPM_VIRT_BIT      = 17;
  localparam int unsigned VPM_FIRST_VID     = 4;   // Register 1 covers ids 4..7

  // Exception levels
  typedef enum logic [1:0]
  {
    VPM_EL0 = 2'h0,
    VPM_EL1 = 2'h1,
    VPM_EL2 = 2'h2,
    VPM_EL3 = 2'h3
  } vpm_el_t;

  // Outcome of an access
  typedef enum logic [2:0]
  {
    VPM_RES_OK    = 3'h0,
    VPM_RES_TRAP2 = 3'h1,
    VPM_RES_TRAP3 = 3'h3,
    VPM_RES_MEM   = 3'h2,
    VPM_RES_UNDEF = 3'h6
  } vpm_res_t;

  // Configuration bits seen by the access checker
  typedef struct packed
  {
    logic lower_level_trap_bit;
    logic nested_virt_enable;
    logic nested_memory_redirect_bit;
    logic host_mode_bit;
    logic host_traps_all_bit;
    logic nonsecure_bit;
    logic secure_level2_enable;
    logic el2_is_64bit;
  } vpm_cfg_t;

  // One system-register access request
  typedef struct packed
  {
    logic       valid;
    logic       write;
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
    vpm_el_t    el;
    logic [63:0] wdata;
  } vpm_req_t;

endpackage

// >>> vpm_access_check.sv
`timescale 1ns/1ps
module vpm_access_check
  import vpm_pkg::*;
(
  input  wire vpm_cfg_t cfg_i,
  input  wire vpm_el_t  el_i,
  input  wire logic     present_i,
  output vpm_res_t      res_o
);

  logic el2_on;

  // Level 2 exists in this security state
  assign el2_on = cfg_i.nonsecure_bit | cfg_i.secure_level2_enable;

  // Trap checks in priority order, then permission
  always_comb
  begin
    res_o = VPM_RES_UNDEF;
    unique case (el_i)
      VPM_EL3: res_o = present_i ? VPM_RES_OK : VPM_RES_UNDEF;
      VPM_EL2:
      begin
        if (!present_i || !el2_on)
          res_o = VPM_RES_UNDEF;
        else if (cfg_i.lower_level_trap_bit)
          res_o = VPM_RES_TRAP3;
        else
          res_o = VPM_RES_OK;
      end
      VPM_EL1:
      begin
        if (!present_i || (el2_on && cfg_i.host_traps_all_bit))
          res_o = VPM_RES_UNDEF;
        else if (cfg_i.nested_virt_enable && cfg_i.nested_memory_redirect_bit)
          res_o = VPM_RES_MEM;
        else if (cfg_i.lower_level_trap_bit && cfg_i.nested_virt_enable)
          res_o = VPM_RES_TRAP3;
        else if (el2_on && cfg_i.el2_is_64bit && cfg_i.host_mode_bit
                 && cfg_i.nested_virt_enable)
          res_o = VPM_RES_TRAP2;
        else
          res_o = VPM_RES_UNDEF;
      end
      VPM_EL0: res_o = VPM_RES_UNDEF;
    endcase
  end

endmodule // vpm_access_check

// >>> vpm_entry_lookup.sv
`timescale 1ns/1ps
module vpm_entry_lookup
  import vpm_pkg::*;
(
  input  wire logic [63:0] map1_i,
  input  wire logic [63:0] map2_i,
  input  wire logic [63:0] map3_i,
  input  wire logic [15:0] vid_i,
  output logic [15:0]      pid_o,
  output logic             hit_o
);

  logic [191:0] table_w;
  logic [3:0]   slot;

  assign table_w = {map3_i, map2_i, map1_i};
  assign slot    = 4'(vid_i - 16'(VPM_FIRST_VID));

  // Entry n of register k sits at bits 16*n+15..16*n
  always_comb
  begin
    // Whole id compared: the 4-bit slot alone would alias ids 20 and up
    hit_o = (vid_i >= 16'(VPM_FIRST_VID))
         && (vid_i < 16'(VPM_FIRST_VID) + 16'h000c);
    pid_o = hit_o ? table_w[slot*VPM_ENTRY_W +: VPM_ENTRY_W] : 16'h0000;
  end

endmodule // vpm_entry_lookup

// >>> tb.sv
`timescale 1ns/1ps
module tb
  import vpm_pkg::*;
;
  typedef struct packed
  {
    logic [7:0]  cfg;
    vpm_el_t     el;
    logic        wr;
    logic [2:0]  op2;
    logic [63:0] wd;
    vpm_res_t    res;
    logic [63:0] rd;
    logic [11:0] ofs;
  } vpm_row_t;

  // Short aliases keep the table rows on one line
  localparam vpm_res_t OK = VPM_RES_OK, UD = VPM_RES_UNDEF, T2 = VPM_RES_TRAP2;
  localparam vpm_res_t T3 = VPM_RES_TRAP3, MM = VPM_RES_MEM;
  localparam vpm_el_t  E0 = VPM_EL0, E1 = VPM_EL1, E2 = VPM_EL2, E3 = VPM_EL3;
  localparam logic [63:0] V1 = 64'h0017_0016_0015_0014, V2 = 64'h00b1_00a1_0091_0081;
  localparam logic [63:0] V3 = 64'h0f03_0e03_0d03_0c03, V4 = 64'h0bb0_0aa0_0990_0880;

  logic         clock_i;
  logic         rst_n_i;
  vpm_req_t     req_i;
  vpm_cfg_t     cfg_i;
  logic [63:0]  identity_i;
  logic [63:0]  hyp_ctrl_i;
  logic [31:0]  valid_bits_i;
  logic [51:0]  redirect_base_address_i;
  logic         use_kernel_label_i;
  logic [15:0]  label_id_i;
  logic         ack_o;
  vpm_res_t     res_o;
  logic [63:0]  rdata_o;
  logic [63:0]  mem_addr_o;
  logic [15:0]  out_id_o;
  logic         out_mapped_o;
  int           n_mismatch = 0;
  int           comparisons = 0;
  logic [191:0] all_maps;
  vpm_row_t     rows[$];

  vpm_map_regs vpm_map_regs_inst
  (
    .clock_i                 (clock_i),
    .rst_n_i                 (rst_n_i),
    .req_i                   (req_i),
    .cfg_i                   (cfg_i),
    .identity_i              (identity_i),
    .hyp_ctrl_i              (hyp_ctrl_i),
    .valid_bits_i            (valid_bits_i),
    .redirect_base_address_i (redirect_base_address_i),
    .use_kernel_label_i      (use_kernel_label_i),
    .label_id_i              (label_id_i),
    .ack_o                   (ack_o),
    .res_o                   (res_o),
    .rdata_o                 (rdata_o),
    .mem_addr_o              (mem_addr_o),
    .out_id_o                (out_id_o),
    .out_mapped_o            (out_mapped_o)
  );

  task automatic chk(input string name, input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask

  // One access; the answer lands on the same edge that takes the request
  task automatic acc(input vpm_row_t r);
    logic [63:0] m;
    m = (r.ofs == 12'h0) ? 64'h0 : {redirect_base_address_i, 12'h000} + 64'(r.ofs);
    @(posedge clock_i);
    cfg_i <= r.cfg;
    req_i <= '{1'h1, r.wr, VPM_OP0, VPM_OP1, VPM_CRN, VPM_CRM, r.op2, r.el, r.wd};
    @(posedge clock_i);
    req_i.valid <= 1'h0;
    #1;
    chk("ack", 64'(ack_o), 64'h1);
    chk("res", 64'(res_o), 64'(r.res));
    chk("rdata", rdata_o, r.rd);
    chk("mem", mem_addr_o, m);
  endtask

  // Expected label worked out from the inputs currently driven
  task automatic xl(input logic [15:0] id, input logic kern);
    logic        en;
    logic [15:0] e;
    // Settings driven by the caller have landed only after this edge
    @(posedge clock_i);
    en = (kern ? hyp_ctrl_i[1] : hyp_ctrl_i[0]) && identity_i[17] && id >= 16'h4
         && (cfg_i.nonsecure_bit || cfg_i.secure_level2_enable) && valid_bits_i[id[4:0]]
         && id < {identity_i[20:18], 2'h0} + 16'h4;
    e = en ? all_maps[(id - 16'h4) * 16 +: 16] : id;
    label_id_i <= id;
    use_kernel_label_i <= kern;
    @(posedge clock_i);
    #1;
    chk("id", 64'(out_id_o), 64'(e));
    chk("mapped", 64'(out_mapped_o), 64'(en));
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Free-running core clock
  initial
  begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end

  // Cuts a hang short; the whole run needs about 120 cycles
  initial
  begin
    repeat (1000) @(posedge clock_i);
    n_mismatch++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    rst_n_i <= 1'h0;
    req_i <= '0;
    cfg_i <= 8'h05;
    identity_i <= 64'he0000;
    hyp_ctrl_i <= 64'h2;
    valid_bits_i <= 32'hfbf0;
    redirect_base_address_i <= 52'h12345_6789a;
    use_kernel_label_i <= 1'h0;
    label_id_i <= 16'h0;
    rows.push_back('{8'h05, E3, 1'h1, 3'h1, V1, OK, 64'h0, 12'h0});
    rows.push_back('{8'h05, E3, 1'h1, 3'h2, V2, OK, 64'h0, 12'h0});
    rows.push_back('{8'h05, E3, 1'h1, 3'h3, V3, OK, 64'h0, 12'h0});
    rows.push_back('{8'h05, E2, 1'h0, 3'h1, 64'h0, OK, V1, 12'h0});
    rows.push_back('{8'h03, E2, 1'h0, 3'h3, 64'h0, OK, V3, 12'h0});
    rows.push_back('{8'h05, E0, 1'h0, 3'h2, 64'h0, UD, 64'h0, 12'h0});
    rows.push_back('{8'h01, E2, 1'h0, 3'h2, 64'h0, UD, 64'h0, 12'h0});
    rows.push_back('{8'h05, E3, 1'h0, 3'h0, 64'h0, UD, 64'h0, 12'h0});
    rows.push_back('{8'h85, E2, 1'h1, 3'h2, 64'h0, T3, 64'h0, 12'h0});
    rows.push_back('{8'h85, E3, 1'h0, 3'h2, 64'h0, OK, V2, 12'h0});
    rows.push_back('{8'hc5, E1, 1'h1, 3'h2, 64'h0, T3, 64'h0, 12'h0});
    rows.push_back('{8'hd5, E1, 1'h0, 3'h2, 64'h0, T3, 64'h0, 12'h0});
    rows.push_back('{8'h55, E1, 1'h0, 3'h1, 64'h0, T2, 64'h0, 12'h0});
    rows.push_back('{8'h54, E1, 1'h0, 3'h1, 64'h0, UD, 64'h0, 12'h0});
    rows.push_back('{8'h65, E1, 1'h1, 3'h1, 64'h0, MM, 64'h0, 12'h948});
    rows.push_back('{8'h65, E1, 1'h0, 3'h2, 64'h0, MM, 64'h0, 12'h950});
    rows.push_back('{8'h61, E1, 1'h0, 3'h3, 64'h0, MM, 64'h0, 12'h958});
    rows.push_back('{8'h0d, E1, 1'h0, 3'h2, 64'h0, UD, 64'h0, 12'h0});
    rows.push_back('{8'h6d, E1, 1'h0, 3'h2, 64'h0, UD, 64'h0, 12'h0});
    rows.push_back('{8'h0d, E2, 1'h0, 3'h2, 64'h0, OK, V2, 12'h0});
    rows.push_back('{8'h05, E1, 1'h0, 3'h2, 64'h0, UD, 64'h0, 12'h0});
    rows.push_back('{8'h05, E3, 1'h0, 3'h1, 64'h0, OK, V1, 12'h0});
    repeat (5) @(posedge clock_i);
    #1;
    chk("rst ack", 64'(ack_o), 64'h0);
    chk("rst res", 64'(res_o), 64'h0);
    @(posedge clock_i);
    rst_n_i <= 1'h1;
    foreach (rows[i])
      acc(rows[i]);
    // Fewer registers implemented
    @(posedge clock_i);
    identity_i <= 64'h60000;
    acc('{8'h05, E3, 1'h0, 3'h2, 64'h0, UD, 64'h0, 12'h0});
    acc('{8'h05, E3, 1'h0, 3'h1, 64'h0, OK, V1, 12'h0});
    @(posedge clock_i);
    identity_i <= 64'h20000;
    acc('{8'h05, E3, 1'h0, 3'h1, 64'h0, UD, 64'h0, 12'h0});
    // Foreign encoding, then a write and read back to back
    @(posedge clock_i);
    identity_i <= 64'he0000;
    req_i <= '{1'h1, 1'h0, VPM_OP0, VPM_OP1, VPM_CRN, 4'h4, 3'h2, E3, 64'h0};
    @(posedge clock_i);
    req_i <= '{1'h1, 1'h1, VPM_OP0, VPM_OP1, VPM_CRN, VPM_CRM, 3'h2, E3, V4};
    #1;
    chk("foreign ack", 64'(ack_o), 64'h0);
    @(posedge clock_i);
    req_i.write <= 1'h0;
    @(posedge clock_i);
    req_i.valid <= 1'h0;
    #1;
    chk("b2b rdata", rdata_o, V4);
    // Translation sweep, then enables, security state and index-max
    all_maps = {V3, V4, V1};
    for (int i = 0; i < 17; i++)
      xl(i[15:0], 1'h1);
    xl(16'h9, 1'h0);
    @(posedge clock_i);
    hyp_ctrl_i <= 64'h1;
    xl(16'h9, 1'h0);
    xl(16'h9, 1'h1);
    @(posedge clock_i);
    cfg_i <= 8'h01;
    xl(16'h9, 1'h0);
    @(posedge clock_i);
    cfg_i <= 8'h05;
    identity_i <= 64'ha0000;
    xl(16'hd, 1'h0);
    xl(16'hb, 1'h0);
    // Reset in mid-run clears every answer; first access right after release
    @(posedge clock_i);
    rst_n_i <= 1'h0;
    repeat (2) @(posedge clock_i);
    #1;
    chk("rst2 ack", 64'(ack_o), 64'h0);
    chk("rst2 id", 64'(out_id_o), 64'h0);
    chk("rst2 mapped", 64'(out_mapped_o), 64'h0);
    @(posedge clock_i);
    rst_n_i <= 1'h1;
    acc('{8'h05, E0, 1'h0, 3'h1, 64'h0, UD, 64'h0, 12'h0});
    wrap_up();
  end
endmodule // tb
